// ---- hw/ieee488_pkg.sv ----
package ieee488_pkg;

	// bus command codes, parity bit dropped
	localparam logic [7:0] CMD_GTL = 8'h01;
	localparam logic [7:0] CMD_PPC = 8'h05;
	localparam logic [7:0] CMD_GET = 8'h08;
	localparam logic [7:0] CMD_TCT = 8'h09;
	localparam logic [7:0] CMD_LLO = 8'h11;
	localparam logic [7:0] CMD_PPU = 8'h15;
	localparam logic [7:0] CMD_SPE = 8'h18;
	localparam logic [7:0] CMD_SPD = 8'h19;
	localparam logic [2:0] PPE_TAG = 3'h6;
	localparam logic [2:0] PPD_TAG = 3'h7;
	localparam int SEC_TAG_LSB = 4;
	localparam logic [7:0] PARITY_MASK = 8'h7f;

	// parallel poll configure word fields
	localparam int PP_LINE_LSB = 0;
	localparam int PP_SENSE_BIT = 3;

	// status byte
	localparam int RQS_BIT = 6;
	localparam logic [7:0] RQS_MASK = 8'h40;
	localparam logic [7:0] STATUS_RST = 8'h00;

	// characters of device-dependent text
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_SEMI = 8'h3b;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_PLUS = 8'h2b;
	localparam logic [7:0] CH_MINUS = 8'h2d;
	localparam logic [7:0] CH_DOT = 8'h2e;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_UP_A = 8'h41;
	localparam logic [7:0] CH_UP_Z = 8'h5a;
	localparam logic [7:0] CH_LO_A = 8'h61;
	localparam logic [7:0] CH_LO_Z = 8'h7a;
	localparam logic [7:0] CASE_MASK = 8'h20;
	localparam logic [31:0] DEC_TEN = 32'h0000_000a;
	localparam logic [1:0] UNIT_MAX = 2'h3;

	typedef enum logic [2:0] {
		CC_LETTER, CC_DIGIT, CC_SIGN, CC_POINT, CC_DELIM, CC_SEP, CC_OTHER
	} char_class_e;

	// one byte accepted from the bus handshake
	typedef struct packed {
		logic atn;
		logic eoi;
		logic [7:0] data;
	} bus_byte_s;

	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
		logic [3:0] qualifier;
	} select_cmd_s;

	typedef struct packed {
		logic [23:0] prefix;
		logic neg;
		logic [31:0] value;
		logic [3:0] decimals;
		logic [23:0] units;
	} data_cmd_s;

endpackage : ieee488_pkg

// ---- hw/char_classifier.sv ----
`timescale 1ns/1ps
module char_classifier
	import ieee488_pkg::*;
(
	input wire logic [7:0] raw_i, // received text byte
	output logic [7:0] folded_o, // byte with lower case folded up
	output char_class_e class_o // token class of the byte
);
	// range checks on the byte
	wire is_lower = (raw_i >= CH_LO_A) && (raw_i <= CH_LO_Z);
	wire is_upper = (raw_i >= CH_UP_A) && (raw_i <= CH_UP_Z);
	wire is_digit = (raw_i >= CH_0) && (raw_i <= CH_9);
	wire is_delim = (raw_i == CH_SEMI) || (raw_i == CH_LF);
	wire is_sep = (raw_i == CH_SPACE) || (raw_i == CH_COMMA);
	wire is_sign = (raw_i == CH_PLUS) || (raw_i == CH_MINUS);

	// case folding and class selection
	assign folded_o = is_lower ? (raw_i & ~CASE_MASK) : raw_i;
	assign class_o = (is_lower || is_upper) ? CC_LETTER :
		is_digit ? CC_DIGIT :
		is_delim ? CC_DELIM :
		is_sep ? CC_SEP :
		is_sign ? CC_SIGN :
		(raw_i == CH_DOT) ? CC_POINT : CC_OTHER;

endmodule : char_classifier

// ---- hw/ppoll_responder.sv ----
`timescale 1ns/1ps
module ppoll_responder
	import ieee488_pkg::*;
(
	input wire logic core_clk_i, // core clock
	input wire logic rst_i, // sync reset
	input wire logic cfg_load_i, // load configure word
	input wire logic [3:0] cfg_word_i, // sense and line
	input wire logic cfg_clear_i, // disable response
	input wire logic poll_i, // atn and eoi both true
	input wire logic rqs_i, // request service bit
	output logic [7:0] drive_o, // data line to pull true
	output logic enabled_o // response configured
);
	logic [2:0] line;
	logic sense;
	logic [7:0] next_drive;

	// answer only while polled, with the configured sense
	wire respond = poll_i && enabled_o && (rqs_i == sense);

	// one select term per data line
	for (genvar g = 0; g < 8; g++) begin : g_line
		assign next_drive[g] = respond && (line == 3'(g));
	end

	// configuration and registered drive
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			enabled_o <= 1'b0;
			line <= 3'h0;
			sense <= 1'b0;
			drive_o <= 8'h00;
		end else begin
			if (cfg_clear_i) begin
				enabled_o <= 1'b0;
			end else if (cfg_load_i) begin
				enabled_o <= 1'b1;
				line <= cfg_word_i[PP_LINE_LSB +: 3];
				sense <= cfg_word_i[PP_SENSE_BIT];
			end
			drive_o <= next_drive;
		end
	end

	pp_release_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!poll_i |=> (drive_o == 8'h00)) else $error("parallel poll line held outside poll");
	pp_line_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(poll_i && enabled_o && (rqs_i == sense) && !cfg_load_i)
		|=> (drive_o == (8'h01 << $past(line)))) else $error("wrong parallel poll line");
	pp_sense_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(rqs_i != sense) |=> (drive_o == 8'h00)) else $error("parallel poll sense inverted");

endmodule : ppoll_responder

// ---- hw/ieee488_device_interface.sv ----
`timescale 1ns/1ps
// Behaviour
// - local lockout disables return-to-local key
// - under lockout only go-to-local or ren false leaves remote
// - lockout alone leaves remote state unchanged
// - universal local (ren false) cancels lockout
// - parallel poll shows rqs on one line
// - configure word: line bits, sense bit
// - take-control command is ignored
// - remote lights indicator, locks panel keys
// - serial poll presents the status byte
// - srq asserted implies status bit six
// - polling clears rqs and releases srq
// - masked status bits raise service request
// - trigger starts sweep or single measurement
// - trigger needs listen addressed and waiting
// - text parsed only in data mode
// - semicolon, linefeed, eoi delimit; space, comma separate
// - numeric entry completes only at delimiter
// - letter case is ignored
// - select: two letters then qualifier digit
// - immediate command acts when received
// - data entry: prefix, number, units
// - atn true command mode, false data
// - go-to-local keeps pending command text
module ieee488_device_interface
	import ieee488_pkg::*;
(
	input wire logic core_clk_i, // core clock
	input wire logic rst_i, // sync reset
	input wire logic rx_valid_i, // byte accepted from bus
	input wire bus_byte_s rx_byte_i, // byte with atn and eoi
	output logic rx_ready_o, // may accept a byte
	input wire logic atn_i, // live atn line
	input wire logic eoi_i, // live eoi line
	input wire logic ren_i, // remote enable line
	input wire logic listen_addressed_i, // addressed to listen
	input wire logic talk_addressed_i, // addressed to talk
	input wire logic tx_done_i, // presented byte taken
	input wire logic local_key_i, // return-to-local key pulse
	input wire logic [7:0] status_i, // operating conditions
	input wire logic [7:0] srq_mask_i, // service request mask
	input wire logic trigger_wait_state_i, // waiting for trigger
	input wire logic cw_or_manual_i, // cw type or manual mode
	output logic [7:0] dio_out_o, // data line values
	output logic [7:0] dio_en_n_o, // low where line driven
	output logic srq_en_n_o, // low while pulling srq
	output logic [7:0] status_byte_o, // status byte with rqs
	output logic remote_indicator_o, // remote state
	output logic panel_lock_o, // keys except local disabled
	output logic return_to_local_key_en_o, // local key usable
	output logic clear_buffer_o, // pending text discarded
	output logic sweep_start_o, // start sweep pulse
	output logic measure_o, // single measurement pulse
	output logic select_valid_o, // select command pulse
	output select_cmd_s select_cmd_o, // select command
	output logic immediate_valid_o, // immediate command pulse
	output logic [23:0] immediate_code_o, // three letters
	output logic data_valid_o, // data entry pulse
	output data_cmd_s data_cmd_o, // data entry command
	output logic parse_error_o // malformed text pulse
);
	typedef enum logic [2:0] {
		PS_IDLE, PS_PFX1, PS_PFX2, PS_PFX3, PS_NUM, PS_UNIT, PS_SKIP
	} parse_e;

	logic lockout, listen_q, spoll_mode, pp_armed, pp_q;
	logic masked_q, rqs, eoi_pend, pp_enabled;
	logic [7:0] pp_drive, fch;
	char_class_e cls;
	parse_e state, next_state;
	logic [23:0] pfx, next_pfx, units, next_units;
	logic neg, next_neg, point, next_point;
	logic [31:0] value, next_value;
	logic [3:0] decs, next_decs;
	logic [1:0] ucnt, next_ucnt;
	logic fire_sel, fire_imm, fire_dat, fire_err;

	// command mode byte decode
	wire cmd_byte = rx_valid_i && rx_byte_i.atn;
	wire [7:0] cmd = rx_byte_i.data & PARITY_MASK;
	wire [2:0] sec_tag = cmd[SEC_TAG_LSB +: 3];
	wire is_gtl = cmd_byte && (cmd == CMD_GTL) && listen_addressed_i;
	wire is_llo = cmd_byte && (cmd == CMD_LLO);
	wire is_get = cmd_byte && (cmd == CMD_GET);
	wire is_ppc = cmd_byte && (cmd == CMD_PPC) && listen_addressed_i;
	wire is_ppu = cmd_byte && (cmd == CMD_PPU);
	wire is_spe = cmd_byte && (cmd == CMD_SPE);
	wire is_spd = cmd_byte && (cmd == CMD_SPD);
	wire is_ppe = cmd_byte && pp_armed && (sec_tag == PPE_TAG);
	wire is_ppd = cmd_byte && pp_armed && (sec_tag == PPD_TAG);
	// take control needs no term: the device never holds control
	// remote and local state
	wire remote = remote_indicator_o;
	wire listen_rise = listen_addressed_i && !listen_q;
	wire key_taken = local_key_i && remote && !lockout;
	wire next_remote = !ren_i ? 1'b0 :
		is_gtl ? 1'b0 :
		listen_rise ? 1'b1 :
		key_taken ? 1'b0 : remote;
	wire next_lockout = !ren_i ? 1'b0 : (is_llo || lockout);
	// trigger acceptance
	wire get_ok = is_get && listen_addressed_i && trigger_wait_state_i;
	// service request and polls
	wire [7:0] masked = status_i & srq_mask_i & ~RQS_MASK;
	wire masked_any = |masked;
	wire srq_rise = masked_any && !masked_q;
	wire spoll_active = spoll_mode && talk_addressed_i && !atn_i;
	wire pp_poll = atn_i && eoi_i;
	wire pp_end = pp_q && !pp_poll && pp_enabled;
	wire polled = (spoll_active && tx_done_i) || pp_end;
	wire next_rqs = srq_rise || (rqs && !polled);
	wire [7:0] next_status = {status_i[7], next_rqs, status_i[5:0]};
	// data lines: status byte in serial poll, else poll line
	assign dio_out_o = spoll_active ? status_byte_o : pp_drive;
	assign dio_en_n_o = spoll_active ? 8'h00 : ~pp_drive;
	assign srq_en_n_o = !rqs;
	assign panel_lock_o = remote;
	assign return_to_local_key_en_o = !lockout;
	// text stream: data mode bytes only, eoi adds a delimiter next cycle
	assign rx_ready_o = !eoi_pend;
	wire text_byte = rx_valid_i && !rx_byte_i.atn && listen_addressed_i && rx_ready_o;
	wire delim_ev = eoi_pend || (text_byte && (cls == CC_DELIM));
	wire char_ev = text_byte && (cls != CC_DELIM);
	wire [3:0] digit = fch[3:0];
	wire num_start = (cls == CC_DIGIT) || (cls == CC_SIGN) || (cls == CC_POINT);
	char_classifier u_class (
		.raw_i(rx_byte_i.data),
		.folded_o(fch),
		.class_o(cls)
	);
	ppoll_responder u_ppoll (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.cfg_load_i(is_ppe),
		.cfg_word_i(cmd[3:0]),
		.cfg_clear_i(is_ppu || is_ppd),
		.poll_i(pp_poll),
		.rqs_i(rqs),
		.drive_o(pp_drive),
		.enabled_o(pp_enabled)
	);

	// parser next state
	always_comb begin
		next_state = state;
		next_pfx = pfx;
		next_neg = neg;
		next_value = value;
		next_decs = decs;
		next_point = point;
		next_units = units;
		next_ucnt = ucnt;
		{fire_sel, fire_imm, fire_dat, fire_err} = 4'h0;
		if (delim_ev) begin
			next_state = PS_IDLE;
			unique case (state)
				PS_IDLE, PS_SKIP: ;
				PS_PFX1, PS_PFX2: fire_err = 1'b1;
				PS_PFX3: fire_imm = 1'b1;
				PS_NUM, PS_UNIT: fire_dat = 1'b1;
			endcase
		end else if (char_ev) begin
			unique case (state)
				PS_IDLE: begin
					if (cls == CC_LETTER) begin
						next_pfx = {16'h0000, fch};
						next_state = PS_PFX1;
					end else if (cls != CC_SEP) begin
						fire_err = 1'b1;
						next_state = PS_SKIP;
					end
				end
				PS_PFX1: begin
					if (cls == CC_LETTER) begin
						next_pfx = {pfx[15:0], fch};
						next_state = PS_PFX2;
					end else begin
						fire_err = 1'b1;
						next_state = PS_SKIP;
					end
				end
				PS_PFX2: begin
					if (cls == CC_DIGIT) begin
						fire_sel = 1'b1;
						next_state = PS_IDLE;
					end else if (cls == CC_LETTER) begin
						next_pfx = {pfx[15:0], fch};
						next_state = PS_PFX3;
					end else begin
						fire_err = 1'b1;
						next_state = PS_SKIP;
					end
				end
				PS_PFX3: begin
					if (cls == CC_LETTER) begin
						fire_imm = 1'b1;
						next_pfx = {16'h0000, fch};
						next_state = PS_PFX1;
					end else if (num_start) begin
						next_state = PS_NUM;
						next_neg = (cls == CC_SIGN) && (fch == CH_MINUS);
						next_value = (cls == CC_DIGIT) ? {28'h000_0000, digit} : 32'h0000_0000;
						next_point = (cls == CC_POINT);
						next_decs = 4'h0;
						next_units = 24'h00_0000;
						next_ucnt = 2'h0;
					end else if (cls != CC_SEP) begin
						fire_err = 1'b1;
						next_state = PS_SKIP;
					end
				end
				PS_NUM: begin
					if (cls == CC_DIGIT) begin
						next_value = 32'(value * DEC_TEN + {28'h000_0000, digit});
						next_decs = point ? 4'(decs + 4'h1) : decs;
					end else if ((cls == CC_POINT) && !point) begin
						next_point = 1'b1;
					end else if (cls == CC_SEP) begin
						next_state = PS_UNIT;
					end else if (cls == CC_LETTER) begin
						next_units = {16'h0000, fch};
						next_ucnt = 2'h1;
						next_state = PS_UNIT;
					end else begin
						fire_err = 1'b1;
						next_state = PS_SKIP;
					end
				end
				PS_UNIT: begin
					if ((cls == CC_LETTER) && (ucnt != UNIT_MAX)) begin
						next_units = {units[15:0], fch};
						next_ucnt = 2'(ucnt + 2'h1);
					end else if (cls != CC_SEP) begin
						fire_err = 1'b1;
						next_state = PS_SKIP;
					end
				end
				PS_SKIP: ;
			endcase
		end
	end
	// remote, lockout and poll state
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			remote_indicator_o <= 1'b0;
			lockout <= 1'b0;
			listen_q <= 1'b0;
			spoll_mode <= 1'b0;
			pp_armed <= 1'b0;
			pp_q <= 1'b0;
			clear_buffer_o <= 1'b0;
		end else begin
			remote_indicator_o <= next_remote;
			lockout <= next_lockout;
			listen_q <= listen_addressed_i;
			spoll_mode <= is_spe || (spoll_mode && !is_spd);
			pp_armed <= cmd_byte ? is_ppc : pp_armed;
			pp_q <= pp_poll;
			clear_buffer_o <= key_taken;
		end
	end

	// service request, status byte and trigger pulses
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rqs <= 1'b0;
			masked_q <= 1'b0;
			status_byte_o <= STATUS_RST;
			sweep_start_o <= 1'b0;
			measure_o <= 1'b0;
		end else begin
			rqs <= next_rqs;
			masked_q <= masked_any;
			status_byte_o <= next_status;
			sweep_start_o <= get_ok && !cw_or_manual_i;
			measure_o <= get_ok && cw_or_manual_i;
		end
	end

	// parser registers; an effective local key flushes the text
	always_ff @(posedge core_clk_i) begin
		if (rst_i || clear_buffer_o) begin
			state <= PS_IDLE;
			eoi_pend <= 1'b0;
		end else begin
			state <= next_state;
			eoi_pend <= text_byte && rx_byte_i.eoi && (cls != CC_DELIM);
		end
		pfx <= next_pfx;
		neg <= next_neg;
		value <= next_value;
		decs <= next_decs;
		point <= next_point;
		units <= next_units;
		ucnt <= next_ucnt;
	end

	// parser outputs
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			select_valid_o <= 1'b0;
			immediate_valid_o <= 1'b0;
			data_valid_o <= 1'b0;
			parse_error_o <= 1'b0;
			select_cmd_o <= '0;
			immediate_code_o <= 24'h00_0000;
			data_cmd_o <= '0;
		end else begin
			select_valid_o <= fire_sel;
			immediate_valid_o <= fire_imm;
			data_valid_o <= fire_dat;
			parse_error_o <= fire_err;
			if (fire_sel) begin
				select_cmd_o <= '{first: pfx[15:8], second: pfx[7:0], qualifier: digit};
			end
			if (fire_imm) begin
				immediate_code_o <= pfx;
			end
			if (fire_dat) begin
				data_cmd_o <= '{prefix: pfx, neg: neg, value: value, decimals: decs,
					units: units};
			end
		end
	end

	reset_state_a: assert property (@(posedge core_clk_i)
		rst_i |=> (!remote && !lockout && srq_en_n_o && (dio_en_n_o == 8'hff)))
		else $error("state after reset not idle");
	llo_keeps_state_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(is_llo && ren_i && !listen_rise && !local_key_i) |=> $stable(remote_indicator_o))
		else $error("local lockout changed remote state");
	lockout_holds_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(lockout && remote && ren_i && !is_gtl) |=> (remote && !clear_buffer_o))
		else $error("left remote under lockout");
	ren_release_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!ren_i |=> (!remote && return_to_local_key_en_o)) else $error("lockout not cancelled");
	gtl_keeps_text_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(is_gtl && !local_key_i) |=> (!remote && !clear_buffer_o))
		else $error("go to local mishandled");
	srq_bit_six_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!srq_en_n_o |-> status_byte_o[RQS_BIT]) else $error("srq without rqs bit");
	poll_clears_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(spoll_active && tx_done_i && !srq_rise) |=> (srq_en_n_o && !status_byte_o[RQS_BIT]))
		else $error("rqs not cleared by poll");
	srq_cause_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$fell(srq_en_n_o) |-> $past(|(status_i & srq_mask_i & ~RQS_MASK)))
		else $error("srq from masked bit");
	trigger_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!get_ok |=> !(sweep_start_o || measure_o)) else $error("trigger taken unaddressed");
	trigger_kind_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		get_ok |=> (measure_o == $past(cw_or_manual_i)) && (sweep_start_o != measure_o))
		else $error("wrong trigger action");
	atn_no_text_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(rx_valid_i && rx_byte_i.atn && !eoi_pend) |=> !(select_valid_o || data_valid_o))
		else $error("command byte parsed as text");
	select_form_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(char_ev && (state == PS_PFX2) && (cls == CC_DIGIT))
		|=> (select_valid_o && (select_cmd_o.qualifier == $past(digit))))
		else $error("select command not decoded");
	entry_needs_delim_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		data_valid_o |-> $past(delim_ev)) else $error("data entry without delimiter");

endmodule : ieee488_device_interface

// ---- verification/ctrl_model.sv ----
`timescale 1ns/1ps
// behavioural bus controller: hands accepted bytes to the device one at a time
module ctrl_model
	import ieee488_pkg::*;
(
	input wire logic core_clk_i, // core clock
	input wire logic ready_i, // device may take a byte
	output logic valid_o, // byte strobe
	output bus_byte_s byte_o, // byte with atn and eoi
	output logic atn_o, // attention line
	output logic eoi_o, // end line
	output logic ren_o, // remote enable
	output logic listen_o, // listen address
	output logic talk_o, // talk address
	output logic done_o // presented byte taken
);
	// idle bus, nobody addressed
	initial begin
		valid_o = 1'b0;
		byte_o = '0;
		atn_o = 1'b1;
		eoi_o = 1'b0;
		ren_o = 1'b0;
		listen_o = 1'b0;
		talk_o = 1'b0;
		done_o = 1'b0;
	end

	// one byte, held until the taking edge, then released to its inverse
	task automatic send(input logic a, input logic e, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk_i);
		#1;
		while (ready_i !== 1'b1 && n < 20) begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
		atn_o = a;
		eoi_o = e;
		byte_o = '{atn: a, eoi: e, data: d};
		valid_o = 1'b1;
		@(posedge core_clk_i);
		#1;
		valid_o = 1'b0;
		eoi_o = 1'b0;
		byte_o = ~byte_o;
	endtask : send
endmodule : ctrl_model

// ---- verification/ieee488_device_interface_test.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
	$display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module ieee488_device_interface_test;
	import ieee488_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic local_key_i = 1'b0;
	logic wait_st = 1'b0;
	logic cw = 1'b0;
	logic [7:0] status = 8'h00;
	logic [7:0] mask = 8'h00;
	logic rx_valid, rx_ready, atn, eoi, ren, listen, talk, tx_done;
	bus_byte_s rx_byte;
	logic [7:0] dio_out, dio_en_n, status_byte;
	logic srq_en_n, remote, lock, key_en, clr, sweep, meas, sel_v, imm_v, dat_v, perr;
	logic [23:0] imm_code;
	select_cmd_s sel_cmd;
	data_cmd_s dat_cmd;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;

	always #4 core_clk_i = ~core_clk_i;

	ctrl_model ctl (.core_clk_i(core_clk_i), .ready_i(rx_ready), .valid_o(rx_valid),
		.byte_o(rx_byte), .atn_o(atn), .eoi_o(eoi), .ren_o(ren), .listen_o(listen),
		.talk_o(talk), .done_o(tx_done));

	ieee488_device_interface uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .rx_ready_o(rx_ready), .atn_i(atn),
		.eoi_i(eoi), .ren_i(ren), .listen_addressed_i(listen), .talk_addressed_i(talk),
		.tx_done_i(tx_done), .local_key_i(local_key_i), .status_i(status),
		.srq_mask_i(mask), .trigger_wait_state_i(wait_st), .cw_or_manual_i(cw),
		.dio_out_o(dio_out), .dio_en_n_o(dio_en_n), .srq_en_n_o(srq_en_n),
		.status_byte_o(status_byte), .remote_indicator_o(remote), .panel_lock_o(lock),
		.return_to_local_key_en_o(key_en), .clear_buffer_o(clr), .sweep_start_o(sweep),
		.measure_o(meas), .select_valid_o(sel_v), .select_cmd_o(sel_cmd),
		.immediate_valid_o(imm_v), .immediate_code_o(imm_code), .data_valid_o(dat_v),
		.data_cmd_o(dat_cmd), .parse_error_o(perr));

	// expected status byte with the request bit in place
	function automatic logic [7:0] exp_status(input logic [7:0] v, input logic rqs);
		return {v[7], rqs, v[5:0]};
	endfunction : exp_status

	task automatic tick();
		@(posedge core_clk_i);
		#1;
	endtask : tick

	task automatic conclude();
		if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude

	task automatic send_text(input string s);
		for (int i = 0; i < s.len(); i++) ctl.send(1'b0, 1'b0, s[i]);
	endtask : send_text

	// masked status rises, wait a bounded time for the request
	task automatic raise_rqs(input logic [7:0] v);
		int n;
		n = 0;
		status = 8'h00;
		tick();
		status = v;
		while (srq_en_n !== 1'b0 && n < 6) begin
			tick();
			n++;
		end
		tick();
	endtask : raise_rqs

	// cut a hang short
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			conclude();
		end
	end

	initial begin
		logic [7:0] v;
		logic [2:0] ln;
		int n;
		v = $urandom(46996);
		repeat (2) @(posedge core_clk_i);
		#1;
		rst_i = 1'b0;
		`CHK(remote, 1'b0)
		`CHK(key_en, 1'b1)
		`CHK({srq_en_n, dio_en_n}, 9'h1ff)
		ctl.ren_o = 1'b1;
		ctl.listen_o = 1'b1;
		tick();
		tick();
		`CHK({remote, lock, key_en}, 3'b111)
		ctl.send(1'b1, 1'b0, CMD_LLO);
		`CHK(key_en, 1'b0)
		`CHK(remote, 1'b1)
		local_key_i = 1'b1;
		tick();
		local_key_i = 1'b0;
		tick();
		`CHK(remote, 1'b1)
		ctl.send(1'b1, 1'b0, CMD_TCT);
		tick();
		`CHK({remote, key_en, dio_en_n}, 10'h2ff)
		ctl.send(1'b1, 1'b0, CMD_GTL);
		`CHK({remote, clr}, 2'b00)
		ctl.ren_o = 1'b0;
		tick();
		tick();
		`CHK(key_en, 1'b1)
		ctl.ren_o = 1'b1;
		ctl.listen_o = 1'b0;
		tick();
		ctl.listen_o = 1'b1;
		tick();
		tick();
		local_key_i = 1'b1;
		tick();
		local_key_i = 1'b0;
		`CHK({remote, clr}, 2'b01)
		status = 8'h00;
		v = ($urandom() & 8'hbf) | 8'h10;
		status = v;
		repeat (3) tick();
		`CHK(srq_en_n, 1'b1)
		mask = 8'($urandom()) | 8'h10;
		raise_rqs(v);
		`CHK(srq_en_n, 1'b0)
		`CHK(status_byte, exp_status(v, 1'b1))
		ctl.send(1'b1, 1'b0, CMD_SPE);
		ctl.talk_o = 1'b1;
		ctl.atn_o = 1'b0;
		tick();
		`CHK(dio_en_n, 8'h00)
		`CHK(dio_out, exp_status(v, 1'b1))
		ctl.done_o = 1'b1;
		tick();
		ctl.done_o = 1'b0;
		tick();
		`CHK({srq_en_n, status_byte[RQS_BIT]}, 2'b10)
		ctl.talk_o = 1'b0;
		ctl.send(1'b1, 1'b0, CMD_SPD);
		// both senses: request set with sense one, then clear with sense zero
		for (int s = 1; s >= 0; s--) begin
			ln = 3'($urandom());
			if (s == 1) raise_rqs(v);
			ctl.send(1'b1, 1'b0, CMD_PPC);
			ctl.send(1'b1, 1'b0, {1'b0, PPE_TAG, s[0], ln});
			tick();
			`CHK(dio_en_n, 8'hff)
			ctl.eoi_o = 1'b1;
			tick();
			tick();
			`CHK(dio_en_n, ~(8'h01 << ln))
			`CHK(dio_out[ln], 1'b1)
			ctl.eoi_o = 1'b0;
			repeat (3) tick();
			`CHK({srq_en_n, dio_en_n}, 9'h1ff)
		end
		// listener stays addressed before each trigger
		for (int c = 0; c < 2; c++) begin
			wait_st = 1'b1;
			cw = c[0];
			ctl.send(1'b1, 1'b0, CMD_GET);
			`CHK({sweep, meas}, {~c[0], c[0]})
		end
		wait_st = 1'b0;
		ctl.send(1'b1, 1'b0, CMD_GET);
		`CHK({sweep, meas}, 2'b00)
		send_text("df5");
		`CHK(sel_v, 1'b1)
		`CHK(sel_cmd, {"D", "F", 4'h5})
		send_text("ipr;");
		`CHK({imm_v, imm_code}, {1'b1, "IPR"})
		n = $urandom_range(999);
		send_text({"sam ", $sformatf("%0d", n), " db"});
		`CHK(dat_v, 1'b0)
		ctl.send(1'b0, 1'b1, "m");
		`CHK(rx_ready, 1'b0)
		tick();
		`CHK(dat_v, 1'b1)
		`CHK({dat_cmd.prefix, dat_cmd.value, dat_cmd.units}, {"SAM", 32'(n), "DBM"})
		send_text("ref 7,dbv\n");
		`CHK({dat_v, dat_cmd.value, dat_cmd.units}, {1'b1, 32'h0000_0007, "DBV"})
		// sign, decimal point and a two-letter unit
		send_text("ref -2.5 db;");
		`CHK(dat_cmd, {"REF", 1'b1, 32'h0000_0019, 4'h1, 8'h00, "DB"})
		// addressed go-to-local between text bytes keeps the pending text
		send_text("df");
		ctl.send(1'b1, 1'b0, CMD_GTL);
		send_text("3");
		`CHK({sel_v, sel_cmd}, {1'b1, "D", "F", 4'h3})
		send_text("x;");
		`CHK(perr, 1'b1)
		// reset in mid-run drops a live lockout
		ctl.send(1'b1, 1'b0, CMD_LLO);
		`CHK(key_en, 1'b0)
		rst_i = 1'b1;
		tick();
		rst_i = 1'b0;
		`CHK({remote, key_en, srq_en_n, dio_en_n}, 11'h3ff)
		conclude();
	end
endmodule : ieee488_device_interface_test
